// ### bca_consts.svh
/*
 * constants of the buffer congestion admission block: register offsets,
 * reset values, field widths and pool sizes.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef BCA_CONSTS_SVH
`define BCA_CONSTS_SVH

// ****************************************************************
// pool sizes and widths
// ****************************************************************
`define BCA_SEG_TOTAL 10'h200
`define BCA_PTR_TOTAL 11'h400
`define BCA_NPORT 4
`define BCA_NQUEUE 8
`define BCA_QSEL_W 3
`define BCA_PSEL_W 2

// ****************************************************************
// reset values
// ****************************************************************
`define BCA_RST_MAX 10'h3FF
`define BCA_RST_QTH 10'h050
`define BCA_RST_RSV 10'h000
`define BCA_TOKEN_LOW 20'h08000
`define BCA_EBS_SHIFT 6
`define BCA_LFSR_SEED 16'hACE1

// ****************************************************************
// drop probabilities in 1/256 steps
// ****************************************************************
`define BCA_P25 8'h40
`define BCA_P50 8'h80
`define BCA_P75 8'hC0

// ****************************************************************
// register offsets
// ****************************************************************
`define BCA_OFS_CTRL 12'h000
`define BCA_OFS_STAT 12'h004
`define BCA_OFS_IMASK 12'h008
`define BCA_OFS_CGN 12'h00C
`define BCA_OFS_GTH 12'h010
`define BCA_OFS_PTH 12'h040
`define BCA_OFS_QTH 12'h100
`define BCA_OFS_FC 12'h200
`define BCA_OFS_RSV 12'h300
`define BCA_OFS_EBS 12'h380

`endif

// ### bca_pkg.sv
/*
 * types of the buffer congestion admission block.
 * assumes bca_consts.svh for sizes.
 */
`include "bca_consts.svh"
package bca_pkg;
	// packet colour from metering
	typedef enum logic [1:0] {
		BCA_RED = 2'h0,
		BCA_YELLOW = 2'h1,
		BCA_GREEN = 2'h2
	} bca_color_e;
	// segment level type
	typedef logic [9:0] bca_lvl_t;
	// min and max pair of one colour
	typedef struct packed {
		bca_lvl_t min_th;
		bca_lvl_t max_th;
	} bca_pair_s;
	// one colour set: red, yellow, green
	typedef struct packed {
		bca_pair_s [2:0] col;
	} bca_cset_s;
	// one admission request
	typedef struct packed {
		logic valid;
		bca_color_e color;
		logic critical;
		logic [`BCA_PSEL_W-1:0] eport;
		logic [`BCA_QSEL_W-1:0] queue;
	} bca_req_s;
	// one admission answer
	typedef struct packed {
		logic valid;
		logic admit;
	} bca_ans_s;
	// per ingress port flow control thresholds
	typedef struct packed {
		bca_lvl_t on_th;
		bca_lvl_t off_th;
	} bca_fc_s;
endpackage

// ### bca_top.sv
/*
 * buffer congestion admission: buffer full discard, critical bypass,
 * queue reservation, per colour early drop at global, port and queue
 * level, per ingress port flow control and congestion interrupts.
 * assumes fill levels arrive from logic on pclk, an apb master on pclk.
 */
`timescale 1ns/1ns
`include "bca_consts.svh"
module bca_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire bca_pkg::bca_req_s req,
	output bca_pkg::bca_ans_s ans,
	input wire logic [9:0] seg_used,
	input wire logic [10:0] ptr_used,
	input wire bca_pkg::bca_lvl_t [`BCA_NPORT-1:0] eport_lvl,
	input wire bca_pkg::bca_lvl_t [`BCA_NQUEUE-1:0] queue_lvl,
	input wire bca_pkg::bca_lvl_t [`BCA_NPORT-1:0] iport_lvl,
	input wire logic [`BCA_NPORT-1:0][19:0] meter_tokens,
	output logic [`BCA_NPORT-1:0] flow_ctrl,
	output logic irq
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		bca_pkg::bca_ans_s ans;
		logic [`BCA_NPORT-1:0] flow_ctrl;
		logic irq;
		logic [1:0] profile;
		logic global_fc_en;
		bca_pkg::bca_lvl_t gfc_on;
		bca_pkg::bca_lvl_t gfc_off;
		logic [`BCA_NPORT-1:0] stat;
		logic [`BCA_NPORT-1:0] imask;
		logic [`BCA_NPORT-1:0] cgn;
		logic [`BCA_NPORT-1:0] mfc;
		bca_pkg::bca_cset_s gth;
		bca_pkg::bca_cset_s [`BCA_NPORT-1:0] pth;
		bca_pkg::bca_cset_s [`BCA_NQUEUE-1:0] qth;
		bca_pkg::bca_lvl_t [`BCA_NQUEUE-1:0] rsv;
		bca_pkg::bca_fc_s [`BCA_NPORT-1:0] fc;
		logic [`BCA_NPORT-1:0][13:0] ebs;
		logic [15:0] lfsr;
	} bca_state_s;

	bca_state_s st_ff; // registered state
	bca_state_s nxt_st; // next state

	// ****************************************************************
	// early drop decision of one level against one pair
	// ****************************************************************
	// returns 1 when the packet is to be dropped
	// the midpoint is floored, so the level that sits on it is judged
	// with the low probability; odd windows lean to the low half
	function automatic logic ed_drop(input bca_pkg::bca_lvl_t lvl,
		input bca_pkg::bca_pair_s pr, input logic [7:0] pmin,
		input logic [7:0] pmax, input logic [7:0] rnd);
		logic [10:0] mid;
		mid = ({1'b0, pr.min_th} + {1'b0, pr.max_th}) >> 1;
		if (lvl < pr.min_th) begin
			ed_drop = 1'b0;
		end else if (lvl > pr.max_th) begin
			ed_drop = 1'b1;
		end else if (pr.min_th == pr.max_th) begin
			ed_drop = 1'b1; // tail drop at the single level
		end else if ({1'b0, lvl} <= mid) begin
			ed_drop = rnd < pmin;
		end else begin
			ed_drop = rnd < pmax;
		end
	endfunction

	// ****************************************************************
	// admission combinational terms
	// ****************************************************************
	logic [7:0] p_lo; // selected low probability
	logic [7:0] p_hi; // selected high probability
	logic buf_full; // segment or pointer pool exhausted
	logic admit_now; // admission result of the current request
	bca_pkg::bca_pair_s gp; // colour pair, global
	bca_pkg::bca_pair_s pp; // colour pair, egress port
	bca_pkg::bca_pair_s qp; // colour pair, egress queue
	bca_pkg::bca_lvl_t qlvl; // filling level of target queue

	// profile decode and admission
	always_comb begin
		case (st_ff.profile)
			2'h1: begin
				p_lo = `BCA_P25;
				p_hi = `BCA_P50;
			end
			2'h2: begin
				p_lo = `BCA_P50;
				p_hi = `BCA_P50;
			end
			2'h3: begin
				p_lo = `BCA_P50;
				p_hi = `BCA_P75;
			end
			default: begin
				p_lo = `BCA_P25;
				p_hi = `BCA_P75;
			end
		endcase
		// full when either pool is used up
		buf_full = (seg_used >= `BCA_SEG_TOTAL) ||
			(ptr_used >= `BCA_PTR_TOTAL);
		gp = st_ff.gth.col[req.color];
		pp = st_ff.pth[req.eport].col[req.color];
		qp = st_ff.qth[req.queue].col[req.color];
		qlvl = queue_lvl[req.queue];
		if (buf_full) begin
			admit_now = 1'b0;
		end else if (req.critical) begin
			admit_now = 1'b1;
		end else if (req.color == bca_pkg::BCA_GREEN &&
			qlvl <= st_ff.rsv[req.queue]) begin
			admit_now = 1'b1;
		end else begin
			admit_now = !(ed_drop(seg_used, gp, p_lo, p_hi,
				st_ff.lfsr[7:0]) ||
				ed_drop(eport_lvl[req.eport], pp, p_lo, p_hi,
				st_ff.lfsr[15:8]) ||
				ed_drop(qlvl, qp, p_lo, p_hi,
				st_ff.lfsr[11:4]));
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	logic wr_en; // apb write access phase
	logic rd_en; // apb read access phase
	logic [`BCA_NPORT-1:0] fc_set; // per port start causes
	logic [`BCA_NPORT-1:0] fc_clr; // per port stop causes all hold
	logic [`BCA_NPORT-1:0] cgn_nx; // next port congestion status
	logic [`BCA_NPORT-1:0] mfc_nx; // next meter flow control state
	logic g_on; // global start condition
	logic g_off; // global stop condition
	logic [3:0] cidx; // colour/index field of address
	logic [31:0] rd; // read data mux
	logic hit; // address mapped

	// register write, read, flow control, interrupt
	always_comb begin
		nxt_st = st_ff;
		wr_en = psel && penable && pwrite;
		rd_en = psel && penable && !pwrite;
		cidx = paddr[5:2];
		rd = 32'h0000_0000;
		hit = 1'b1;
		// free running generator
		nxt_st.lfsr = {st_ff.lfsr[14:0], st_ff.lfsr[15] ^
			st_ff.lfsr[13] ^ st_ff.lfsr[12] ^ st_ff.lfsr[10]};
		// admission answer, one cycle after the request
		nxt_st.ans.valid = req.valid;
		nxt_st.ans.admit = req.valid && admit_now;
		// flow control causes
		g_on = st_ff.global_fc_en && seg_used > st_ff.gfc_on;
		g_off = !st_ff.global_fc_en || seg_used < st_ff.gfc_off;
		for (int i = 0; i < `BCA_NPORT; i++) begin
			if (iport_lvl[i] > st_ff.fc[i].on_th) begin
				cgn_nx[i] = 1'b1;
			end else if (iport_lvl[i] < st_ff.fc[i].off_th) begin
				cgn_nx[i] = 1'b0;
			end else begin
				cgn_nx[i] = st_ff.cgn[i];
			end
			if (meter_tokens[i] < `BCA_TOKEN_LOW) begin
				mfc_nx[i] = 1'b1;
			end else if (meter_tokens[i] >
				({6'h00, st_ff.ebs[i]} << `BCA_EBS_SHIFT)) begin
				mfc_nx[i] = 1'b0;
			end else begin
				mfc_nx[i] = st_ff.mfc[i];
			end
			// any start cause, all stop causes
			fc_set[i] = g_on || cgn_nx[i] || mfc_nx[i];
			fc_clr[i] = g_off && !cgn_nx[i] && !mfc_nx[i];
		end
		nxt_st.cgn = cgn_nx;
		nxt_st.mfc = mfc_nx;
		nxt_st.flow_ctrl = fc_set | (st_ff.flow_ctrl & ~fc_clr);
		// read decode
		if (paddr == `BCA_OFS_CTRL) begin
			rd = {9'h000, st_ff.gfc_off, st_ff.gfc_on, st_ff.global_fc_en,
				st_ff.profile};
		end else if (paddr == `BCA_OFS_STAT) begin
			rd = {28'h0000000, st_ff.stat};
		end else if (paddr == `BCA_OFS_IMASK) begin
			rd = {28'h0000000, st_ff.imask};
		end else if (paddr == `BCA_OFS_CGN) begin
			rd = {28'h0000000, st_ff.cgn};
		end else if (paddr[11:4] == `BCA_OFS_GTH >> 4 &&
			cidx[1:0] != 2'h3) begin
			rd = {12'h000, st_ff.gth.col[cidx[1:0]]};
		end else if (paddr[11:6] == `BCA_OFS_PTH >> 6 && cidx[1:0] != 2'h3) begin
			rd = {12'h000, st_ff.pth[cidx[3:2]].col[cidx[1:0]]};
		end else if (paddr[11:8] == `BCA_OFS_QTH >> 8 && paddr[3:2] != 2'h3 &&
			paddr[7:4] < 4'h8) begin
			rd = {12'h000, st_ff.qth[paddr[6:4]].col[paddr[3:2]]};
		end else if (paddr[11:4] == `BCA_OFS_FC >> 4) begin
			rd = {12'h000, st_ff.fc[paddr[3:2]]};
		end else if (paddr[11:5] == `BCA_OFS_RSV >> 5) begin
			rd = {22'h000000, st_ff.rsv[paddr[4:2]]};
		end else if (paddr[11:4] == `BCA_OFS_EBS >> 4) begin
			rd = {18'h00000, st_ff.ebs[paddr[3:2]]};
		end else begin
			hit = 1'b0;
		end
		// writes land at the access edge only
		if (wr_en && hit) begin
			if (paddr == `BCA_OFS_CTRL) begin
				nxt_st.profile = pwdata[1:0];
				nxt_st.global_fc_en = pwdata[2];
				nxt_st.gfc_on = pwdata[12:3];
				nxt_st.gfc_off = pwdata[22:13];
			end else if (paddr == `BCA_OFS_IMASK) begin
				nxt_st.imask = pwdata[`BCA_NPORT-1:0];
			end else if (paddr[11:4] == `BCA_OFS_GTH >> 4) begin
				nxt_st.gth.col[cidx[1:0]] = pwdata[19:0];
			end else if (paddr[11:6] == `BCA_OFS_PTH >> 6) begin
				nxt_st.pth[cidx[3:2]].col[cidx[1:0]] = pwdata[19:0];
			end else if (paddr[11:8] == `BCA_OFS_QTH >> 8) begin
				nxt_st.qth[paddr[6:4]].col[paddr[3:2]] = pwdata[19:0];
			end else if (paddr[11:4] == `BCA_OFS_FC >> 4) begin
				nxt_st.fc[paddr[3:2]] = pwdata[19:0];
			end else if (paddr[11:5] == `BCA_OFS_RSV >> 5) begin
				nxt_st.rsv[paddr[4:2]] = pwdata[9:0];
			end else if (paddr[11:4] == `BCA_OFS_EBS >> 4) begin
				nxt_st.ebs[paddr[3:2]] = pwdata[13:0];
			end
		end
		// sticky change bits: write one clears, new change wins
		nxt_st.stat = st_ff.stat;
		if (wr_en && paddr == `BCA_OFS_STAT) begin
			nxt_st.stat = st_ff.stat & ~pwdata[`BCA_NPORT-1:0];
		end
		nxt_st.stat = nxt_st.stat | (cgn_nx ^ st_ff.cgn);
		nxt_st.irq = |(nxt_st.stat & nxt_st.imask);
		// apb answer: ready in the access phase, zero wait
		nxt_st.pready = psel && !penable;
		nxt_st.pslverr = psel && !penable && !hit;
		nxt_st.prdata = (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
		if (rd_en) begin
			nxt_st.prdata = st_ff.prdata;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// reset values of every field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.gth <= {6{`BCA_RST_MAX}};
			st_ff.pth <= {(6*`BCA_NPORT){`BCA_RST_MAX}};
			st_ff.qth <= {(6*`BCA_NQUEUE){`BCA_RST_QTH}};
			st_ff.rsv <= {`BCA_NQUEUE{`BCA_RST_RSV}};
			st_ff.fc <= {(2*`BCA_NPORT){`BCA_RST_MAX}};
			st_ff.gfc_on <= `BCA_RST_MAX;
			st_ff.gfc_off <= `BCA_RST_MAX;
			st_ff.lfsr <= `BCA_LFSR_SEED;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign ans = st_ff.ans;
	assign flow_ctrl = st_ff.flow_ctrl;
	assign irq = st_ff.irq;

	// ****************************************************************
	// assertions
	// ****************************************************************
	// a frame offered while a pool is used up
	sequence s_req_full;
		req.valid && buf_full;
	endsequence
	// the answer one cycle later refuses it
	sequence s_ans_refused;
		ans.valid && !ans.admit;
	endsequence
	// every stop cause of port 0 holds and no start cause does
	sequence s_fc0_stop_causes;
		!st_ff.global_fc_en &&
		iport_lvl[0] < st_ff.fc[0].off_th &&
		iport_lvl[0] <= st_ff.fc[0].on_th &&
		meter_tokens[0] >= `BCA_TOKEN_LOW &&
		meter_tokens[0] > ({6'h00, st_ff.ebs[0]} << `BCA_EBS_SHIFT);
	endsequence

	// full buffer refuses every frame, critical ones too
	AST_FULL_DROP: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_req_full |=> s_ans_refused)
		else $error("frame admitted while buffer full");
	// critical frames pass whenever room is left
	AST_CRIT_ADMIT: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid && req.critical && !buf_full |=> ans.admit)
		else $error("critical frame refused");
	// green within the queue reservation skips early drop
	AST_RSV_GREEN: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid && !buf_full && req.color == bca_pkg::BCA_GREEN &&
		queue_lvl[req.queue] <= st_ff.rsv[req.queue] |=> ans.admit)
		else $error("green frame within reservation refused");
	// below every minimum the frame is never dropped
	AST_BELOW_MIN: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid && !buf_full && seg_used < gp.min_th &&
		eport_lvl[req.eport] < pp.min_th && qlvl < qp.min_th
		|=> ans.admit)
		else $error("frame below minimum dropped");
	// above the queue maximum a non-critical frame outside the green reservation is always dropped
	AST_ABOVE_MAX: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid && !buf_full && !req.critical && qlvl > qp.max_th &&
		!(req.color == bca_pkg::BCA_GREEN && qlvl <= st_ff.rsv[req.queue])
		|=> !ans.admit)
		else $error("frame above maximum admitted");
	// equal minimum and maximum drop at that very level
	AST_TAIL_DROP: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid && !buf_full && !req.critical &&
		qp.min_th == qp.max_th && qlvl == qp.min_th &&
		!(req.color == bca_pkg::BCA_GREEN && qlvl <= st_ff.rsv[req.queue])
		|=> !ans.admit)
		else $error("frame at tail drop level admitted");
	// an admit only ever answers a request
	AST_ANS_ONE: assert property (
		@(posedge pclk) disable iff (!presetn)
		ans.admit |-> $past(req.valid))
		else $error("answer without request");
	// local congestion above the upper threshold starts pause
	AST_FC_ON: assert property (
		@(posedge pclk) disable iff (!presetn)
		iport_lvl[0] > st_ff.fc[0].on_th |=> flow_ctrl[0])
		else $error("flow control not started");
	// pause ends once every stop cause holds together
	AST_FC_STOP: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_fc0_stop_causes |=> !flow_ctrl[0])
		else $error("flow control held with every stop cause");
	// a status change is latched and drives the interrupt level
	AST_IRQ: assert property (
		@(posedge pclk) disable iff (!presetn)
		$changed(st_ff.cgn) |->
		((st_ff.cgn ^ $past(st_ff.cgn)) & ~st_ff.stat) == '0 &&
		irq == |(st_ff.stat & st_ff.imask))
		else $error("congestion change not latched or not signalled");
	// few committed tokens start meter based pause
	AST_MFC: assert property (
		@(posedge pclk) disable iff (!presetn)
		meter_tokens[1] < `BCA_TOKEN_LOW |=> flow_ctrl[1])
		else $error("meter flow control not started");
endmodule // bca_top

// ### bca_far_model.sv
/*
 * far side model: the ingress side offers frames and takes the verdict.
 * assumes bca_pkg is compiled and the bench supplies pclk.
 */
`timescale 1ns/1ns
module bca_far_model (
	input wire logic pclk,
	output bca_pkg::bca_req_s req,
	input wire bca_pkg::bca_ans_s ans
);
	// ********
	// frame offer
	// ********
	initial req = '0; // idle at time zero
	// offer one frame, hand back what came one cycle later
	task automatic send(input logic [1:0] c, input logic k,
		input logic [1:0] p, input logic [2:0] q,
		output logic v, output logic a);
		@(posedge pclk);
		req <= '{1'b1, bca_pkg::bca_color_e'(c), k, p, q};
		@(posedge pclk);
		// idle fields carry garbage, never the last frame
		req <= '{1'b0, bca_pkg::bca_color_e'(~c), ~k, ~p, ~q};
		// the verdict still stands until this edge updates it
		@(posedge pclk);
		v = ans.valid;
		a = ans.admit;
	endtask
endmodule // bca_far_model

// ### tb_top.sv
/*
 * bench for bca_top: apb master, fill levels, scenario tasks.
 * assumes bca_pkg, bca_consts.svh, bca_top and bca_far_model.
 */
`timescale 1ns/1ns
`include "bca_consts.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin fails++; \
$display("Error %0t: got %0h exp %0h", $time, g, x); end end
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0; // active low
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	bca_pkg::bca_req_s req;
	bca_pkg::bca_ans_s ans;
	logic [9:0] seg_used = 10'h000;
	logic [10:0] ptr_used = 11'h000;
	bca_pkg::bca_lvl_t [`BCA_NPORT-1:0] eport_lvl = '0;
	bca_pkg::bca_lvl_t [`BCA_NQUEUE-1:0] queue_lvl = '0;
	bca_pkg::bca_lvl_t [`BCA_NPORT-1:0] iport_lvl = '0;
	logic [`BCA_NPORT-1:0][19:0] meter_tokens = {4{20'hFFFFF}};
	logic [`BCA_NPORT-1:0] flow_ctrl;
	logic irq;
	logic [31:0] rv; // last read data
	logic re; // last error flag
	int fails = 0;
	int cmp_count = 0;
	always #2 pclk = ~pclk; // 250 MHz
	bca_top i_bca_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .req, .ans, .seg_used,
		.ptr_used, .eport_lvl, .queue_lvl, .iport_lvl, .meter_tokens,
		.flow_ctrl, .irq);
	bca_far_model i_bca_far_model (.pclk, .req, .ans);
	// ********
	// bus and frame helpers
	// ********
	task automatic end_sim();
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			end_sim();
		end
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask
	// threshold word: min above max
	function automatic logic [31:0] pr(input logic [9:0] mn, mx);
		return {12'h000, mn, mx};
	endfunction
	// colour 0 red, 1 yellow, 2 green; x is the expected verdict
	task automatic frm(input logic [1:0] c, input logic k,
		input logic [1:0] p, input logic [2:0] q, input logic x);
		logic v;
		logic a;
		i_bca_far_model.send(c, k, p, q, v, a);
		`CHK(v, 1'b1)
		`CHK(a, x)
	endtask
	// flow control outputs after the inputs have settled
	task automatic fcw(input logic [3:0] x);
		repeat (3) @(posedge pclk);
		`CHK(flow_ctrl, x)
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_reset();
		rd(12'h100);
		`CHK(rv, 32'h00014050)
		rd(12'h31C);
		`CHK(rv, 32'h00000000)
		rd(12'h000);
		`CHK(rv[1:0], 2'h0)
		rd(12'h018);
		`CHK(rv, 32'h000FFFFF)
		rd(12'hFFC);
		`CHK({re, rv}, 33'h100000000)
	endtask
	task automatic t_full();
		seg_used <= 10'h200;
		frm(2'h2, 1'b1, 2'h0, 3'h0, 1'b0);
		frm(2'h0, 1'b0, 2'h0, 3'h0, 1'b0);
		seg_used <= 10'h1FF;
		queue_lvl[0] <= 10'h3FF;
		frm(2'h2, 1'b1, 2'h0, 3'h0, 1'b1);
		frm(2'h2, 1'b0, 2'h0, 3'h0, 1'b0);
		ptr_used <= 11'h400;
		frm(2'h1, 1'b1, 2'h3, 3'h0, 1'b0);
		ptr_used <= 11'h3FF;
		frm(2'h1, 1'b1, 2'h3, 3'h0, 1'b1);
		ptr_used <= 11'h000;
		seg_used <= 10'h000;
		queue_lvl[0] <= 10'h000;
	endtask
	task automatic t_col();
		wr(12'h110, pr(10'h010, 10'h010));
		queue_lvl[1] <= 10'h020;
		frm(2'h0, 1'b0, 2'h0, 3'h1, 1'b0);
		frm(2'h1, 1'b0, 2'h0, 3'h1, 1'b1);
		frm(2'h2, 1'b0, 2'h0, 3'h1, 1'b1);
		wr(12'h010, pr(10'h030, 10'h030));
		seg_used <= 10'h040;
		frm(2'h0, 1'b0, 2'h0, 3'h2, 1'b0);
		seg_used <= 10'h020;
		frm(2'h0, 1'b0, 2'h0, 3'h2, 1'b1);
		wr(12'h054, pr(10'h030, 10'h030));
		eport_lvl[1] <= 10'h040;
		frm(2'h1, 1'b0, 2'h1, 3'h2, 1'b0);
		frm(2'h1, 1'b0, 2'h0, 3'h2, 1'b1);
		queue_lvl[4] <= 10'h04F;
		frm(2'h2, 1'b0, 2'h0, 3'h4, 1'b1);
		queue_lvl[4] <= 10'h050;
		frm(2'h2, 1'b0, 2'h0, 3'h4, 1'b0);
		queue_lvl[4] <= 10'h051;
		frm(2'h2, 1'b0, 2'h0, 3'h4, 1'b0);
		seg_used <= 10'h000;
		eport_lvl[1] <= 10'h000;
	endtask
	task automatic t_resv();
		wr(12'h308, 32'h00000060);
		queue_lvl[2] <= 10'h060;
		frm(2'h2, 1'b0, 2'h0, 3'h2, 1'b1);
		frm(2'h1, 1'b0, 2'h0, 3'h2, 1'b0);
		queue_lvl[2] <= 10'h061;
		frm(2'h2, 1'b0, 2'h0, 3'h2, 1'b0);
		queue_lvl[2] <= 10'h000;
	endtask
	// drop rate in each half of the window, every profile
	task automatic t_prob();
		int lo [4] = '{`BCA_P25, `BCA_P25, `BCA_P50, `BCA_P50};
		int hi [4] = '{`BCA_P75, `BCA_P50, `BCA_P50, `BCA_P75};
		int drops;
		int x;
		logic v;
		logic a;
		wr(12'h138, pr(10'h000, 10'h080));
		for (int p = 0; p < 4; p++) begin
			// profile 0 is left at its reset value
			if (p > 0) begin
				wr(12'h000, p);
			end
			for (int h = 0; h < 2; h++) begin
				queue_lvl[3] <= (h != 0) ? 10'h060 : 10'h020;
				x = (h != 0) ? hi[p] : lo[p];
				drops = 0;
				repeat (256) begin
					i_bca_far_model.send(2'h2, 1'b0, 2'h0, 3'h3, v, a);
					drops += (a === 1'b0);
				end
				`CHK(drops > x - 40 && drops < x + 40, 1'b1)
			end
		end
		queue_lvl[3] <= 10'h000;
	endtask
	task automatic t_fc();
		wr(12'h200, pr(10'h040, 10'h020));
		iport_lvl[0] <= 10'h041;
		fcw(4'h1);
		rd(12'h00C);
		`CHK(rv[3:0], 4'h1)
		iport_lvl[0] <= 10'h030;
		fcw(4'h1);
		meter_tokens[0] <= 20'h07FFF;
		iport_lvl[0] <= 10'h010;
		fcw(4'h1);
		meter_tokens[0] <= 20'hFFFFF;
		fcw(4'h0);
		wr(12'h384, 32'h00000300);
		meter_tokens[1] <= 20'h00100;
		fcw(4'h2);
		rd(12'h00C);
		`CHK(rv[3:0], 4'h0)
		meter_tokens[1] <= 20'h09000;
		fcw(4'h2);
		meter_tokens[1] <= 20'h0C001;
		fcw(4'h0);
	endtask
	task automatic t_irq();
		rd(12'h004);
		`CHK(rv[3:0], 4'h1)
		`CHK(irq, 1'b0)
		wr(12'h008, 32'h00000001);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		wr(12'h004, 32'h00000001);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		rd(12'h004);
		`CHK(rv[3:0], 4'h0)
	endtask
	// ********
	// main sequence and watchdog
	// ********
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_full();
		t_col();
		t_resv();
		t_prob();
		t_fc();
		t_irq();
		end_sim();
	end
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule // tb_top
